// [pira_pkg.sv]
/*
  Package for the process image register access block.
  Holds the control byte layout, register numbers, unlock code and reset values.
  Assumes nothing of its surroundings.
*/
package pira_pkg;

  localparam int unsigned CTL_REG_MODE_BIT = 7;
  localparam int unsigned CTL_WRITE_BIT = 6;
  localparam int unsigned CTL_NUM_MSB = 5;
  localparam logic [5:0] REG_UNLOCK_NUM = 6'h1F;
  localparam logic [5:0] REG_FEATURE_NUM = 6'h20;
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] UNLOCK_RESET = 16'h0000;
  localparam logic [15:0] FEATURE_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int unsigned NUM_REGS = 64;

  typedef struct packed {
    logic [7:0] ctl;
    logic [15:0] word;
  } pira_image_t;

endpackage

// [pira_word_reg.sv]
/*
  One 16-bit user register with a write strobe.
  Assumes the strobe and data come from logic on the same clock.
*/
`timescale 1ns/10ps
module pira_word_reg
  import pira_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Write side.
  input wire logic i_we,
  input wire logic [15:0] i_data,
  // Stored value.
  output logic [15:0] o_value
);

  logic [15:0] value_q;
  logic [15:0] value_d;

  always_comb
  begin
    value_d = value_q;
    if (i_we)
    begin
      value_d = i_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      value_q <= RESET_VAL;
    end
    else
    begin
      value_q <= value_d;
    end
  end

  assign o_value = value_q;

endmodule

// [pira_core.sv]
/*
  Register access through the cyclic process image of an output terminal.
  The controller writes a control byte and an outgoing data word each cycle;
  the block answers with a status byte and an incoming data word.
  Assumes the process image arrives from logic on the same clock.
*/
`timescale 1ns/10ps
module pira_core
  import pira_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Process image from the controller.
  input wire pira_image_t i_out_image,
  // Process data path when register mode is off.
  input wire logic [15:0] i_proc_status_word,
  input wire logic [7:0] i_proc_status_byte,
  output logic [15:0] o_proc_out_word,
  output logic [7:0] o_proc_ctl_byte,
  // Process image back to the controller.
  output pira_image_t o_in_image,
  // Register state for the terminal logic.
  output logic [15:0] o_feature_settings,
  output logic o_write_enabled
);

  logic reg_mode;
  logic wr_req;
  logic [5:0] reg_num;
  logic new_req;
  logic wr_allowed;
  logic [15:0] unlock_val;
  logic [15:0] feature_val;
  logic [15:0] gen_val [NUM_REGS];
  logic [NUM_REGS-1:0] we_vec;
  logic [7:0] last_ctl_q;
  logic [7:0] last_ctl_d;
  pira_image_t in_image_q;
  pira_image_t in_image_d;
  logic [15:0] proc_word_q;
  logic [15:0] proc_word_d;
  logic [7:0] proc_ctl_q;
  logic [7:0] proc_ctl_d;
  logic [15:0] feat_q;
  logic unlocked_q;
  logic unlocked_d;

  assign reg_mode = i_out_image.ctl[CTL_REG_MODE_BIT];
  assign wr_req = i_out_image.ctl[CTL_WRITE_BIT];
  assign reg_num = i_out_image.ctl[CTL_NUM_MSB:0];
  // A held request is carried out once only.
  assign new_req = reg_mode && (i_out_image.ctl != last_ctl_q);
  assign wr_allowed = unlocked_q || (reg_num == REG_UNLOCK_NUM);
  assign unlock_val = gen_val[REG_UNLOCK_NUM];
  assign feature_val = gen_val[REG_FEATURE_NUM];

  // One storage word per register number; the two documented ones are special.
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_regs
    assign we_vec[g] = new_req && wr_req && wr_allowed && (reg_num == 6'(g));
    pira_word_reg #(
      .RESET_VAL((g == int'(REG_FEATURE_NUM)) ? FEATURE_RESET : UNLOCK_RESET)
    ) u_reg (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_we(we_vec[g]),
      .i_data(i_out_image.word),
      .o_value(gen_val[g])
    );
  end

  always_comb
  begin
    last_ctl_d = reg_mode ? i_out_image.ctl : STATUS_RESET;
    unlocked_d = unlocked_q;
    if (we_vec[REG_UNLOCK_NUM])
    begin
      unlocked_d = (i_out_image.word == UNLOCK_CODE);
    end
    in_image_d = in_image_q;
    proc_word_d = proc_word_q;
    proc_ctl_d = proc_ctl_q;
    if (!reg_mode)
    begin
      in_image_d.ctl = i_proc_status_byte;
      in_image_d.word = i_proc_status_word;
      proc_word_d = i_out_image.word;
      proc_ctl_d = i_out_image.ctl;
    end
    else if (new_req)
    begin
      if (wr_req)
      begin
        in_image_d.ctl = i_out_image.ctl ^ 8'h40;
        in_image_d.word = WORD_RESET;
      end
      else
      begin
        in_image_d.ctl = i_out_image.ctl;
        in_image_d.word = gen_val[reg_num];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      last_ctl_q <= STATUS_RESET;
      unlocked_q <= 1'b0;
      in_image_q <= '0;
      proc_word_q <= WORD_RESET;
      proc_ctl_q <= STATUS_RESET;
      feat_q <= FEATURE_RESET;
    end
    else
    begin
      last_ctl_q <= last_ctl_d;
      unlocked_q <= unlocked_d;
      in_image_q <= in_image_d;
      proc_word_q <= proc_word_d;
      proc_ctl_q <= proc_ctl_d;
      feat_q <= feature_val;
    end
  end

  assign o_in_image = in_image_q;
  assign o_proc_out_word = proc_word_q;
  assign o_proc_ctl_byte = proc_ctl_q;
  assign o_feature_settings = feat_q;
  assign o_write_enabled = unlocked_q;

  property p_write_ack;
    @(posedge i_clk) disable iff (i_rst)
    (new_req && wr_req) |=> (o_in_image.ctl == ($past(i_out_image.ctl) ^ 8'h40));
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write ack wrong");

  property p_read_ack;
    @(posedge i_clk) disable iff (i_rst)
    (new_req && !wr_req) |=> (o_in_image.ctl == $past(i_out_image.ctl));
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read ack wrong");

  property p_read_data;
    @(posedge i_clk) disable iff (i_rst)
    (new_req && !wr_req && reg_num == REG_UNLOCK_NUM) |=> (o_in_image.word == $past(unlock_val));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_unlock;
    @(posedge i_clk) disable iff (i_rst)
    (we_vec[REG_UNLOCK_NUM] && i_out_image.word == UNLOCK_CODE) |=> o_write_enabled;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed");

  property p_relock;
    @(posedge i_clk) disable iff (i_rst)
    (we_vec[REG_UNLOCK_NUM] && i_out_image.word == 16'h0000) |=> !o_write_enabled;
  endproperty
  a_relock: assert property (p_relock) else $error("relock failed");

  property p_protect;
    @(posedge i_clk) disable iff (i_rst)
    (!unlocked_q && reg_num == REG_FEATURE_NUM) |=> $stable(feature_val);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write taken");

  property p_feature_write;
    @(posedge i_clk) disable iff (i_rst)
    (we_vec[REG_FEATURE_NUM]) |=> ##1 (o_feature_settings == $past(i_out_image.word, 2));
  endproperty
  a_feature_write: assert property (p_feature_write) else $error("feature not stored");

  property p_proc_pass;
    @(posedge i_clk) disable iff (i_rst)
    !reg_mode |=> (o_proc_out_word == $past(i_out_image.word));
  endproperty
  a_proc_pass: assert property (p_proc_pass) else $error("process data lost");

  // Register traffic must not leak onto the process outputs.
  property p_proc_hold;
    @(posedge i_clk) disable iff (i_rst)
    reg_mode |=> ($stable(o_proc_out_word) && $stable(o_proc_ctl_byte));
  endproperty
  a_proc_hold: assert property (p_proc_hold) else $error("process outputs moved");

  // The answer to a held request stays on the image until the request changes.
  property p_status_stands;
    @(posedge i_clk) disable iff (i_rst)
    (reg_mode && !new_req) |=> $stable(o_in_image);
  endproperty
  a_status_stands: assert property (p_status_stands) else $error("answer not held");

  property p_read_no_write;
    @(posedge i_clk) disable iff (i_rst)
    (new_req && !wr_req) |=>
      ($stable(feature_val) && $stable(unlock_val) && $stable(o_write_enabled));
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read changed state");

  c_write: cover property (@(posedge i_clk) disable iff (i_rst) new_req && wr_req);
  c_read: cover property (@(posedge i_clk) disable iff (i_rst) new_req && !wr_req);
  c_unlocked_feature: cover property (@(posedge i_clk) disable iff (i_rst)
    we_vec[REG_FEATURE_NUM]);
  c_refused_write: cover property (@(posedge i_clk) disable iff (i_rst)
    new_req && wr_req && !wr_allowed);
  c_held_request: cover property (@(posedge i_clk) disable iff (i_rst)
    reg_mode && !new_req);

endmodule

// [pira_ctl_model.sv]
/*
  Controller model that drives the outgoing process image.
  Assumes its tasks are called just after a rising edge of the clock.
*/
`timescale 1ns/10ps
module pira_ctl_model
  import pira_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Image exchange with the block.
  input wire pira_image_t i_in_image,
  output pira_image_t o_image
);
  initial o_image = '0;
  task automatic idle(input logic [7:0] ctl, input logic [15:0] word);
    o_image = {ctl, word};
  endtask
  // The incoming word is returned but only trusted by callers after reads.
  task automatic req(input logic [7:0] ctl, input logic [15:0] word,
      output pira_image_t ans, output logic ok);
    logic [7:0] ack;
    ack = ctl[6] ? (ctl ^ 8'h40) : ctl;
    ok = 1'b0;
    o_image = {ctl, word};
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge i_clk);
      #1;
      ok = (i_in_image.ctl === ack);
    end
    ans = i_in_image;
    // Leave register mode so an identical request can follow.
    o_image = {8'h00, ~word};
    repeat (2) @(posedge i_clk);
    #1;
  endtask
endmodule

// [process_image_register_access_bench.sv]
/*
  Self-checking bench for the process image register access block.
  Assumes the controller model file is compiled before it.
*/
`timescale 1ns/10ps
module process_image_register_access_bench
  import pira_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctl;
    logic [15:0] word;
    logic [15:0] rd;
    logic we;
  } pira_row_t;
  localparam pira_row_t ROWS [10] = '{
    '{8'h9F, 16'hFFFF, 16'h0000, 1'b0}, '{8'hE0, 16'h0002, 16'h0000, 1'b0},
    '{8'hA0, 16'hFFFF, 16'h0000, 1'b0}, '{8'hDF, 16'h1235, 16'h0000, 1'b1},
    '{8'hE0, 16'h0002, 16'h0000, 1'b1}, '{8'hA0, 16'h5555, 16'h0002, 1'b1},
    '{8'h9F, 16'hFFFF, 16'h1235, 1'b1}, '{8'hDF, 16'h0000, 16'h0000, 1'b0},
    '{8'hE0, 16'h0005, 16'h0000, 1'b0}, '{8'hA0, 16'h0000, 16'h0002, 1'b0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] pword = 16'h0000;
  logic [7:0] pbyte = 8'h00;
  logic [15:0] pout;
  logic [7:0] pctl;
  logic [15:0] feat;
  logic we;
  logic ok;
  pira_image_t out_image;
  pira_image_t in_image;
  pira_image_t ans;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  pira_core DUT (.i_clk(clk), .i_rst(rst), .i_out_image(out_image),
    .i_proc_status_word(pword), .i_proc_status_byte(pbyte), .o_proc_out_word(pout),
    .o_proc_ctl_byte(pctl), .o_in_image(in_image), .o_feature_settings(feat),
    .o_write_enabled(we));
  pira_ctl_model MODEL (.i_clk(clk), .i_in_image(in_image), .o_image(out_image));
  always #4 clk = ~clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic finish_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      finish_test();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    check({8'h00, in_image.ctl}, 16'h0000);
    check_bit(we, 1'b0);
    foreach (ROWS[i])
    begin
      MODEL.req(ROWS[i].ctl, ROWS[i].word, ans, ok);
      check_bit(ok, 1'b1);
      if (!ROWS[i].ctl[6])
        check(ans.word, ROWS[i].rd);
      check_bit(we, ROWS[i].we);
    end
    check(feat, 16'h0002);
    // A request held for several cycles is taken once and its answer stands.
    MODEL.idle(8'hDF, UNLOCK_CODE);
    repeat (3) @(posedge clk);
    #1;
    check({8'h00, in_image.ctl}, 16'h009F);
    check_bit(we, 1'b1);
    pbyte = 8'h5A;
    pword = 16'hC3A5;
    MODEL.idle(8'h12, 16'hBEEF);
    repeat (3) @(posedge clk);
    #1;
    check({in_image.ctl, 8'h00}, 16'h5A00);
    check(in_image.word, 16'hC3A5);
    check({pctl, 8'h00}, 16'h1200);
    check(pout, 16'hBEEF);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    check(feat, FEATURE_RESET);
    check_bit(we, 1'b0);
    finish_test();
  end
endmodule
